// ===== mfcr_pkg.sv
// Package with offsets, fields and carriers for the motion and buffer control registers
package mfcr_pkg;

    // Register offsets
    localparam logic [7:0] MFCR_OFS_MOTION = 8'h09;
    localparam logic [7:0] MFCR_OFS_CMD    = 8'h0A;
    localparam logic [7:0] MFCR_OFS_WTM    = 8'h13;
    localparam logic [7:0] MFCR_OFS_BUFCTL = 8'h14;

    // Motion control field positions
    localparam int MFCR_BIT_ACT_SEL = 6;
    localparam int MFCR_BIT_SIGMOT  = 3;
    localparam int MFCR_BIT_NOMOT   = 2;
    localparam int MFCR_BIT_ANYMOT  = 1;
    localparam int MFCR_BIT_TAP     = 0;

    // Buffer control field positions
    localparam int MFCR_BIT_RD_MODE = 7;
    localparam int MFCR_SIZE_LSB    = 2;
    localparam int MFCR_SIZE_W      = 2;

    // Reset values
    localparam logic [7:0] MFCR_RST_MOTION = 8'h00;
    localparam logic [7:0] MFCR_RST_CMD    = 8'h00;
    localparam logic [7:0] MFCR_RST_WTM    = 8'h00;
    localparam logic [7:0] MFCR_RST_BUFCTL = 8'h00;

    // Smallest buffer capacity, doubled per size code step
    localparam logic [7:0] MFCR_CAP_BASE = 8'h10;

    // Command code that hands the buffer to the host, value arbitrary
    localparam logic [7:0] MFCR_CMD_RD_MODE_DEF = 8'h05;

    // One register access from the host interface
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } mfcr_req_t;

    // Motion detection events, one bit per engine
    typedef struct packed {
        logic sig_motion;
        logic no_motion;
        logic any_motion;
        logic tap;
    } mfcr_evt_t;

endpackage : mfcr_pkg

// ===== mfcr_regs.sv
// Motion detection and buffer control register slice
`timescale 1ns/1ps
module mfcr_regs
    import mfcr_pkg::*;
#(
    parameter logic [7:0] CMD_RD_MODE = MFCR_CMD_RD_MODE_DEF
) (
    // Clock, reset, enable
    input  wire logic       CLK,
    input  wire logic       SRST,
    input  wire logic       CE,
    // Register port
    input  wire mfcr_req_t  REG_REQ,
    output logic [7:0]      REG_RDATA,
    // Command launch
    output logic            CMD_STROBE,
    output logic [7:0]      CMD_CODE,
    // Motion engines
    output mfcr_evt_t       ENGINE_EN,
    input  wire mfcr_evt_t  MOTION_EVT,
    output logic            IRQ_PIN_A,
    output logic            IRQ_PIN_B,
    // Buffer control
    input  wire logic       SAMPLE_VALID,
    output logic            SAMPLE_STORE,
    output logic            BUF_RD_MODE,
    output logic [7:0]      BUF_CAPACITY,
    output logic [7:0]      WATERMARK_LEVEL
);

    logic [7:0] motion_r,  motion_nxt;
    logic [7:0] cmd_r,     cmd_nxt;
    logic [7:0] wtm_r,     wtm_nxt;
    logic [7:0] bufctl_r,  bufctl_nxt;
    logic [7:0] rdata_r,   rdata_nxt;
    logic       strobe_r,  strobe_nxt;
    logic       irq_a_r,   irq_a_nxt;
    logic       irq_b_r,   irq_b_nxt;
    logic [7:0] cap_r,     cap_nxt;
    logic       act_evt;
    logic       cmd_wr;

    // Any event from an enabled engine
    assign act_evt = |(MOTION_EVT & motion_r[3:0]);
    assign cmd_wr  = REG_REQ.wr && (REG_REQ.addr == MFCR_OFS_CMD);

    // Next register state
    always_comb begin
        motion_nxt = motion_r;
        cmd_nxt    = cmd_r;
        wtm_nxt    = wtm_r;
        bufctl_nxt = bufctl_r;
        strobe_nxt = 1'b0;
        if (REG_REQ.wr) begin
            unique case (REG_REQ.addr)
                MFCR_OFS_MOTION: begin
                    // Only select and engine bits are kept
                    motion_nxt = REG_REQ.wdata & 8'h4F;
                end
                MFCR_OFS_CMD: begin
                    cmd_nxt    = REG_REQ.wdata;
                    strobe_nxt = 1'b1;
                end
                MFCR_OFS_WTM: begin
                    wtm_nxt = REG_REQ.wdata;
                end
                MFCR_OFS_BUFCTL: begin
                    // Mode and size bits; host clears read mode here
                    bufctl_nxt = REG_REQ.wdata & 8'h8C;
                end
                default: begin
                end
            endcase
        end
        // Command sets read mode by itself
        if (cmd_wr && (REG_REQ.wdata == CMD_RD_MODE)) begin
            bufctl_nxt[MFCR_BIT_RD_MODE] = 1'b1;
        end
    end

    // Read data, one cycle after the address
    always_comb begin
        unique case (REG_REQ.addr)
            MFCR_OFS_MOTION: rdata_nxt = motion_r;
            MFCR_OFS_CMD:    rdata_nxt = cmd_r;
            MFCR_OFS_WTM:    rdata_nxt = wtm_r;
            MFCR_OFS_BUFCTL: rdata_nxt = bufctl_r;
            default:         rdata_nxt = 8'h00;
        endcase
    end

    // Interrupt routing and capacity decode
    always_comb begin
        irq_a_nxt = act_evt && motion_r[MFCR_BIT_ACT_SEL];
        irq_b_nxt = act_evt && !motion_r[MFCR_BIT_ACT_SEL];
        cap_nxt   = MFCR_CAP_BASE << bufctl_r[MFCR_SIZE_LSB +: MFCR_SIZE_W];
    end

    // State registers
    always_ff @(posedge CLK) begin
        if (SRST) begin
            motion_r <= MFCR_RST_MOTION;
            cmd_r    <= MFCR_RST_CMD;
            wtm_r    <= MFCR_RST_WTM;
            bufctl_r <= MFCR_RST_BUFCTL;
            rdata_r  <= 8'h00;
            strobe_r <= 1'b0;
            irq_a_r  <= 1'b0;
            irq_b_r  <= 1'b0;
            cap_r    <= MFCR_CAP_BASE;
        end else if (CE) begin
            motion_r <= motion_nxt;
            cmd_r    <= cmd_nxt;
            wtm_r    <= wtm_nxt;
            bufctl_r <= bufctl_nxt;
            rdata_r  <= rdata_nxt;
            strobe_r <= strobe_nxt;
            irq_a_r  <= irq_a_nxt;
            irq_b_r  <= irq_b_nxt;
            cap_r    <= cap_nxt;
        end
    end

    // Outputs
    assign REG_RDATA        = rdata_r;
    assign CMD_STROBE       = strobe_r && CE;
    assign CMD_CODE         = cmd_r;
    assign ENGINE_EN        = motion_r[3:0];
    assign IRQ_PIN_A        = irq_a_r;
    assign IRQ_PIN_B        = irq_b_r;
    assign BUF_RD_MODE      = bufctl_r[MFCR_BIT_RD_MODE];
    assign SAMPLE_STORE     = SAMPLE_VALID && !bufctl_r[MFCR_BIT_RD_MODE] && CE;
    assign BUF_CAPACITY     = cap_r;
    assign WATERMARK_LEVEL  = wtm_r;

    // Checks
    property p_route_b;
        @(posedge CLK) disable iff (SRST)
        (CE && act_evt && !motion_r[MFCR_BIT_ACT_SEL]) |=> (IRQ_PIN_B && !IRQ_PIN_A);
    endproperty
    a_route_b: assert property (p_route_b) else $error("event not routed to pin b");

    property p_route_a;
        @(posedge CLK) disable iff (SRST)
        (CE && act_evt && motion_r[MFCR_BIT_ACT_SEL]) |=> (IRQ_PIN_A && !IRQ_PIN_B);
    endproperty
    a_route_a: assert property (p_route_a) else $error("event not routed to pin a");

    property p_sig_en;
        @(posedge CLK) disable iff (SRST)
        (CE && REG_REQ.wr && REG_REQ.addr == MFCR_OFS_MOTION) |=> (ENGINE_EN.sig_motion == $past(REG_REQ.wdata[3]));
    endproperty
    a_sig_en: assert property (p_sig_en) else $error("sig motion enable not written");

    property p_no_en;
        @(posedge CLK) disable iff (SRST)
        (CE && REG_REQ.wr && REG_REQ.addr == MFCR_OFS_MOTION) |=> (ENGINE_EN.no_motion == $past(REG_REQ.wdata[2]));
    endproperty
    a_no_en: assert property (p_no_en) else $error("no motion enable not written");

    property p_any_tap_en;
        @(posedge CLK) disable iff (SRST)
        (CE && REG_REQ.wr && REG_REQ.addr == MFCR_OFS_MOTION)
            |=> (ENGINE_EN.any_motion == $past(REG_REQ.wdata[1])) && (ENGINE_EN.tap == $past(REG_REQ.wdata[0]));
    endproperty
    a_any_tap_en: assert property (p_any_tap_en) else $error("any motion or tap enable not written");

    property p_wtm;
        @(posedge CLK) disable iff (SRST)
        (CE && REG_REQ.wr && REG_REQ.addr == MFCR_OFS_WTM) |=> (WATERMARK_LEVEL == $past(REG_REQ.wdata));
    endproperty
    a_wtm: assert property (p_wtm) else $error("watermark not written");

    property p_cmd_rd;
        @(posedge CLK) disable iff (SRST)
        (CE && cmd_wr && REG_REQ.wdata == CMD_RD_MODE) |=> BUF_RD_MODE && (CMD_STROBE || !CE);
    endproperty
    a_cmd_rd: assert property (p_cmd_rd) else $error("read mode command not applied");

    property p_no_store;
        @(posedge CLK) disable iff (SRST)
        BUF_RD_MODE |-> !SAMPLE_STORE;
    endproperty
    a_no_store: assert property (p_no_store) else $error("sample stored in read mode");

    property p_cap;
        @(posedge CLK) disable iff (SRST)
        (CE && REG_REQ.wr && REG_REQ.addr == MFCR_OFS_BUFCTL && REG_REQ.wdata[3:2] == 2'h1 && !cmd_wr)
            |=> CE [*2] |-> (BUF_CAPACITY == 8'h20);
    endproperty
    a_cap: assert property (p_cap) else $error("size code 1 not 32 samples");

    property p_strobe_one;
        @(posedge CLK) disable iff (SRST)
        (CMD_STROBE && !cmd_wr) |=> !CMD_STROBE;
    endproperty
    a_strobe_one: assert property (p_strobe_one) else $error("command strobe longer than one cycle");

    property p_store_resume;
        @(posedge CLK) disable iff (SRST)
        (CE && REG_REQ.wr && REG_REQ.addr == MFCR_OFS_BUFCTL && !REG_REQ.wdata[7]) ##1 (SAMPLE_VALID && CE) |-> SAMPLE_STORE;
    endproperty
    a_store_resume: assert property (p_store_resume) else $error("storing not resumed after clear");

    property p_irq_quiet;
        @(posedge CLK) disable iff (SRST)
        (CE && !(|(MOTION_EVT & ENGINE_EN))) |=> (!IRQ_PIN_A && !IRQ_PIN_B);
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("interrupt without enabled event");

endmodule : mfcr_regs

// ===== mfcr_host.sv
// Host processor model driving single-byte register accesses
`timescale 1ns/1ps
module mfcr_host
    import mfcr_pkg::*;
(
    // Clock and read data from the device
    input  wire logic       clk,
    input  wire logic [7:0] rdata,
    // Request towards the device
    output mfcr_req_t       req
);
    // Idle bus at time zero
    initial req = '0;

    // Write held across one rising edge, released at the next falling edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req = '{wr: 1'b1, addr: a, wdata: d};
        @(negedge clk);
        req.wr = 1'b0;
        req.wdata = ~d;
    endtask : wr

    // Read: address sampled at one rising edge, data taken at the next falling edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        req.addr = a;
        @(negedge clk);
        d = rdata;
    endtask : rd

    // Hand the buffer back to write mode, keeping the size field
    task automatic clr_rd(input logic [7:0] keep);
        wr(MFCR_OFS_BUFCTL, keep & 8'h7F);
    endtask : clr_rd
endmodule : mfcr_host

// ===== mfcr_regs_test.sv
// Self-checking testbench for the motion and buffer control registers
`timescale 1ns/1ps
module mfcr_regs_test;
    import mfcr_pkg::*;
    logic        CLK = 1'b0;
    logic        SRST = 1'b1;
    logic        CE = 1'b1;
    logic        SAMPLE_VALID = 1'b0;
    mfcr_evt_t   MOTION_EVT = '0;
    mfcr_req_t   REG_REQ;
    mfcr_evt_t   ENGINE_EN;
    logic [7:0]  REG_RDATA, CMD_CODE, BUF_CAPACITY, WATERMARK_LEVEL;
    logic        CMD_STROBE, IRQ_PIN_A, IRQ_PIN_B, SAMPLE_STORE, BUF_RD_MODE;
    int          mismatches = 0;
    int          tests_run = 0;
    logic [31:0] seed = 32'hCC6C1873;
    logic [7:0]  v, d, w;

    // 200 MHz clock
    always #2.5 CLK = ~CLK;

    mfcr_regs mfcr_regs_inst (.CLK(CLK), .SRST(SRST), .CE(CE), .REG_REQ(REG_REQ), .REG_RDATA(REG_RDATA),
        .CMD_STROBE(CMD_STROBE), .CMD_CODE(CMD_CODE), .ENGINE_EN(ENGINE_EN), .MOTION_EVT(MOTION_EVT),
        .IRQ_PIN_A(IRQ_PIN_A), .IRQ_PIN_B(IRQ_PIN_B), .SAMPLE_VALID(SAMPLE_VALID), .SAMPLE_STORE(SAMPLE_STORE),
        .BUF_RD_MODE(BUF_RD_MODE), .BUF_CAPACITY(BUF_CAPACITY), .WATERMARK_LEVEL(WATERMARK_LEVEL));
    mfcr_host mfcr_host_inst (.clk(CLK), .rdata(REG_RDATA), .req(REG_REQ));

    // Xorshift step for repeatable stimulus
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs

    // Expected pins {a, b}: enabled events routed by the select bit
    function automatic logic [7:0] exp_irq(input logic [3:0] ev, input logic [7:0] m);
        logic hit;
        hit = |(ev & m[3:0]);
        return {6'h00, hit & m[6], hit & ~m[6]};
    endfunction : exp_irq

    // Byte comparison
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic wrap_up;
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        repeat (16) @(posedge CLK);
        @(negedge CLK);
        SRST = 1'b0;
        mfcr_host_inst.rd(MFCR_OFS_MOTION, d);
        chk(d, MFCR_RST_MOTION, "motion reset");
        mfcr_host_inst.rd(MFCR_OFS_BUFCTL, d);
        chk(d, MFCR_RST_BUFCTL, "bufctl reset");
        chk(BUF_CAPACITY, 8'h10, "capacity reset");
        chk(WATERMARK_LEVEL, 8'h00, "watermark reset");
        $display("Test reset done");
        // Motion enables and interrupt routing, corners first
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            v = (i == 0) ? 8'h4F : (i == 1) ? 8'hB0 : seed[7:0];
            mfcr_host_inst.wr(MFCR_OFS_MOTION, v);
            chk({4'h0, ENGINE_EN}, {4'h0, v[3:0]}, "engines");
            MOTION_EVT = (i < 2) ? 4'hF : seed[11:8];
            @(negedge CLK);
            chk({6'h00, IRQ_PIN_A, IRQ_PIN_B}, exp_irq(MOTION_EVT, v), "irq route");
            MOTION_EVT = '0;
            mfcr_host_inst.rd(MFCR_OFS_MOTION, d);
            chk(d, v & 8'h4F, "motion read");
        end
        $display("Test motion done");
        // Watermark threshold, full-scale first
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            w = (i == 0) ? 8'hFF : seed[7:0];
            mfcr_host_inst.wr(MFCR_OFS_WTM, w);
            chk(WATERMARK_LEVEL, w, "watermark");
            mfcr_host_inst.rd(MFCR_OFS_WTM, d);
            chk(d, w, "watermark read");
        end
        // Frozen while clock enable is low
        CE = 1'b0;
        mfcr_host_inst.wr(MFCR_OFS_WTM, ~w);
        CE = 1'b1;
        chk(WATERMARK_LEVEL, w, "ce freeze");
        $display("Test watermark done");
        // Every size code, write mode storing samples
        SAMPLE_VALID = 1'b1;
        for (int c = 0; c < 4; c++) begin
            seed = xs(seed);
            v = {1'b0, seed[6:4], c[1:0], seed[1:0]};
            mfcr_host_inst.wr(MFCR_OFS_BUFCTL, v);
            @(negedge CLK);
            chk(BUF_CAPACITY, 8'h10 << c, "capacity");
            chk({7'h00, SAMPLE_STORE}, 8'h01, "store");
            mfcr_host_inst.rd(MFCR_OFS_BUFCTL, d);
            chk(d, v & 8'h0C, "bufctl read");
        end
        $display("Test size done");
        // Command hands buffer to host, host hands it back
        mfcr_host_inst.wr(MFCR_OFS_CMD, MFCR_CMD_RD_MODE_DEF);
        chk({CMD_STROBE, BUF_RD_MODE, 6'h00}, 8'hC0, "command");
        chk(CMD_CODE, MFCR_CMD_RD_MODE_DEF, "code");
        chk({7'h00, SAMPLE_STORE}, 8'h00, "halt");
        mfcr_host_inst.rd(MFCR_OFS_BUFCTL, d);
        chk(d, 8'h8C, "rd mode read");
        chk({7'h00, CMD_STROBE}, 8'h00, "strobe width");
        mfcr_host_inst.clr_rd(d);
        chk({BUF_RD_MODE, SAMPLE_STORE, 6'h00}, 8'h40, "resume");
        mfcr_host_inst.wr(MFCR_OFS_CMD, ~MFCR_CMD_RD_MODE_DEF);
        chk({CMD_STROBE, BUF_RD_MODE, 6'h00}, 8'h80, "other cmd");
        $display("Test command done");
        // Unmapped place, then reset in mid-run
        mfcr_host_inst.wr(8'h20, 8'hFF);
        mfcr_host_inst.rd(8'h20, d);
        chk(d, 8'h00, "unmapped");
        SRST = 1'b1;
        @(negedge CLK);
        SRST = 1'b0;
        chk({BUF_CAPACITY[7:4], ENGINE_EN}, 8'h10, "reset again");
        chk(WATERMARK_LEVEL | CMD_CODE, 8'h00, "regs reset again");
        $display("Test misc done");
        wrap_up();
    end

    // Watchdog against a hang
    initial begin
        repeat (5000) @(posedge CLK);
        mismatches++;
        $display("Error at %0t: watchdog expired", $time);
        wrap_up();
    end
endmodule : mfcr_regs_test
